// ==== hw/cfc_pkg.sv ====
// shared constants for the chain frame check and single-device command handler
package cfc_pkg;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
    localparam logic [15:0] CRC_GOOD = 16'h0000;
    localparam logic [2:0] REQ_SINGLE_READ = 3'h0;
    localparam logic [2:0] REQ_SINGLE_WRITE = 3'h1;
    localparam int FRAME_TYPE_BIT = 7;
    localparam int REQ_LSB = 4;
    localparam int SIZE_LSB = 0;
    localparam logic [5:0] ADDR_MASK = 6'h3f;
    localparam logic [6:0] READ_COUNT_MAX = 7'h7f;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int MAX_WRITE = 8;
    localparam logic [3:0] HDR_LEN = 4'h4;
    localparam logic [5:0] RESET_DEV_ADDR = 6'h00;
endpackage

// ==== hw/cfc_fifo.sv ====
// byte fifo with valid/ready on both sides
`timescale 1ns/1ps
module cfc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // cfc_fifo

// ==== hw/cfc_frame.sv ====
// frame check, relay and single-device read/write handler for the chain link
`timescale 1ns/1ps
module cfc_frame (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic [5:0] DEV_ADDR,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_VALID,
    output logic RX_READY,
    input wire logic RX_END,
    output logic [7:0] FWD_DATA,
    output logic FWD_VALID,
    input wire logic FWD_READY,
    output logic [7:0] RSP_DATA,
    output logic RSP_VALID,
    output logic RSP_LAST,
    input wire logic RSP_READY,
    output logic REG_WE,
    output logic REG_RE,
    output logic [15:0] REG_ADDR,
    output logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_HIT,
    output logic CRC_FAULT,
    output logic FRAME_OK
);
    // ==========================================================
    // reset release
    logic rst_meta_reg;
    logic rst_n_reg;
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // ==========================================================
    // crc step, lsb first with reflected polynomial
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
        logic [15:0] c;
        c = crc ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ cfc_pkg::CRC_POLY_REFL) : (c >> 1);
        end
        return c;
    endfunction

    // ==========================================================
    // relay path through the fifo; rx stalls when the fifo is full
    logic fifo_in_ready;
    logic rx_take;
    logic rsp_valid_reg;
    cfc_fifo #(
        .WIDTH(cfc_pkg::FIFO_WIDTH),
        .DEPTH(cfc_pkg::FIFO_DEPTH)
    ) cfc_fifo_inst (
        .clk(CLOCK),
        .rst_n(rst_n_reg),
        .in_data(RX_DATA),
        .in_valid(RX_VALID),
        .in_ready(fifo_in_ready),
        .out_data(FWD_DATA),
        .out_valid(FWD_VALID),
        .out_ready(FWD_READY)
    );

    typedef enum logic [2:0] {
        ST_RX,
        ST_CHECK,
        ST_WRITE,
        ST_READ,
        ST_CRC_LO,
        ST_CRC_HI
    } cfc_state_type;
    cfc_state_type state_reg;

    // frames are only accepted while idle with no response byte still pending;
    // every accepted byte goes to the relay whatever its crc turns out to be
    assign RX_READY = fifo_in_ready && (state_reg == ST_RX) && !rsp_valid_reg;
    assign rx_take = RX_VALID && RX_READY;

    // ==========================================================
    // receive: running crc and capture of header/data
    logic [15:0] crc_reg;
    logic [3:0] idx_reg;
    logic [7:0] hdr_reg [4];
    logic [7:0] wbuf_reg [cfc_pkg::MAX_WRITE];
    logic [3:0] count_reg;

    always_ff @(posedge CLOCK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            crc_reg <= cfc_pkg::CRC_INIT;
            idx_reg <= '0;
            count_reg <= '0;
        end else if (rx_take) begin
            crc_reg <= crc_byte(crc_reg, RX_DATA);
            if (idx_reg != 4'hf) begin
                idx_reg <= idx_reg + 4'h1;
            end
            count_reg <= idx_reg;
            if (RX_END) begin
                idx_reg <= '0;
            end
        end else if (state_reg == ST_CHECK) begin
            crc_reg <= cfc_pkg::CRC_INIT;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (rx_take) begin
            if (idx_reg < cfc_pkg::HDR_LEN) begin
                hdr_reg[idx_reg[1:0]] <= RX_DATA;
            end else if (idx_reg < cfc_pkg::HDR_LEN + 4'(cfc_pkg::MAX_WRITE)) begin
                wbuf_reg[3'(idx_reg - cfc_pkg::HDR_LEN)] <= RX_DATA;
            end
        end
    end

    // ==========================================================
    // frame decode
    logic [2:0] req_kind;
    logic [2:0] size_fld;
    logic addr_hit;
    logic is_read;
    logic is_write;
    assign req_kind = hdr_reg[0][cfc_pkg::REQ_LSB +: 3];
    assign size_fld = hdr_reg[0][cfc_pkg::SIZE_LSB +: 3];
    assign addr_hit = (hdr_reg[1][7:6] == 2'b00)
        && ((hdr_reg[1][5:0] & cfc_pkg::ADDR_MASK) == DEV_ADDR);
    // index of the final crc byte: header, n+1 data bytes, two crc bytes
    function automatic logic [3:0] last_idx(input logic [2:0] n);
        return cfc_pkg::HDR_LEN + {1'b0, n} + 4'h2;
    endfunction
    // a read carries one count byte; a frame of the wrong length is ignored
    assign is_read = hdr_reg[0][cfc_pkg::FRAME_TYPE_BIT]
        && (req_kind == cfc_pkg::REQ_SINGLE_READ) && (size_fld == 3'h0)
        && (count_reg == last_idx(3'h0));
    assign is_write = hdr_reg[0][cfc_pkg::FRAME_TYPE_BIT]
        && (req_kind == cfc_pkg::REQ_SINGLE_WRITE)
        && (count_reg == last_idx(size_fld));

    // ==========================================================
    // execution: walks the register port for writes and reads
    logic [7:0] left_reg;
    logic [2:0] wpos_reg;
    logic [15:0] addr_reg;
    logic [15:0] tx_crc_reg;
    logic [7:0] rsp_data_reg;
    logic rsp_last_reg;
    logic rsp_move;
    logic rsp_load;
    logic crc_bad;
    logic [7:0] rd_byte;
    assign rsp_move = rsp_valid_reg && RSP_READY;
    // next data byte only once the previous one has left
    assign rsp_load = (state_reg == ST_READ) && (!rsp_valid_reg || rsp_move);
    assign crc_bad = (crc_reg != cfc_pkg::CRC_GOOD);
    assign rd_byte = REG_HIT ? REG_RDATA : cfc_pkg::UNMAPPED_DATA;

    always_ff @(posedge CLOCK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= ST_RX;
            left_reg <= '0;
        end else begin
            case (state_reg)
                ST_RX: begin
                    if (rx_take && RX_END) begin
                        state_reg <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    // a bad frame is dropped whole before any decode is acted on
                    if (crc_bad) begin
                        state_reg <= ST_RX;
                    end else if (is_write && addr_hit) begin
                        left_reg <= {5'h00, size_fld};
                        state_reg <= ST_WRITE;
                    end else if (is_read && addr_hit) begin
                        left_reg <= {1'b0, wbuf_reg[0][6:0] & cfc_pkg::READ_COUNT_MAX};
                        state_reg <= ST_READ;
                    end else begin
                        state_reg <= ST_RX;
                    end
                end
                ST_WRITE: begin
                    left_reg <= left_reg - 8'h01;
                    if (left_reg == 8'h00) begin
                        state_reg <= ST_RX;
                    end
                end
                ST_READ: begin
                    if (rsp_load) begin
                        left_reg <= left_reg - 8'h01;
                        if (left_reg == 8'h00) begin
                            state_reg <= ST_CRC_LO;
                        end
                    end
                end
                ST_CRC_LO: begin
                    if (rsp_move) begin
                        state_reg <= ST_CRC_HI;
                    end
                end
                ST_CRC_HI: begin
                    if (rsp_move) begin
                        state_reg <= ST_RX;
                    end
                end
                default: begin
                    state_reg <= ST_RX;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            wpos_reg <= '0;
        end else if (state_reg == ST_CHECK) begin
            wpos_reg <= '0;
        end else if (state_reg == ST_WRITE) begin
            wpos_reg <= wpos_reg + 3'h1;
        end
    end

    // register address walks up one place per write or per data byte read
    always_ff @(posedge CLOCK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            addr_reg <= '0;
        end else if (state_reg == ST_CHECK) begin
            addr_reg <= {hdr_reg[2], hdr_reg[3]};
        end else if (state_reg == ST_WRITE || rsp_load) begin
            addr_reg <= addr_reg + 16'h0001;
        end
    end

    // ==========================================================
    // response: data bytes, then crc low and high; last marks the high byte
    always_ff @(posedge CLOCK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            tx_crc_reg <= cfc_pkg::CRC_INIT;
            rsp_data_reg <= '0;
            rsp_valid_reg <= 1'b0;
            rsp_last_reg <= 1'b0;
        end else begin
            if (state_reg == ST_CHECK) begin
                tx_crc_reg <= cfc_pkg::CRC_INIT;
            end
            if (rsp_load) begin
                rsp_data_reg <= rd_byte;
                rsp_valid_reg <= 1'b1;
                tx_crc_reg <= crc_byte(tx_crc_reg, rd_byte);
            end
            if (state_reg == ST_CRC_LO && rsp_move) begin
                rsp_data_reg <= tx_crc_reg[7:0];
            end
            if (state_reg == ST_CRC_HI && rsp_move) begin
                rsp_data_reg <= tx_crc_reg[15:8];
                rsp_last_reg <= 1'b1;
            end
            // the high crc byte is released only after the return to idle
            if (state_reg == ST_RX && rsp_move) begin
                rsp_valid_reg <= 1'b0;
                rsp_last_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // verdict pulses, one cycle each, raised from the check cycle
    always_ff @(posedge CLOCK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            CRC_FAULT <= 1'b0;
            FRAME_OK <= 1'b0;
        end else begin
            // a bad frame reports nothing but the crc fault
            CRC_FAULT <= (state_reg == ST_CHECK) && crc_bad;
            FRAME_OK <= (state_reg == ST_CHECK) && !crc_bad;
        end
    end

    // writes to unmapped addresses are dropped through REG_HIT
    assign REG_WE = (state_reg == ST_WRITE) && REG_HIT;
    assign REG_RE = rsp_load;
    assign REG_ADDR = addr_reg;
    assign REG_WDATA = wbuf_reg[wpos_reg];
    assign RSP_DATA = rsp_data_reg;
    assign RSP_VALID = rsp_valid_reg;
    assign RSP_LAST = rsp_last_reg;
endmodule // cfc_frame

// ==== tb/cfc_frame_assertions.sv ====
// port assertions for the chain frame handler
`timescale 1ns/1ps
module cfc_frame_assertions (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic RX_VALID,
    input wire logic RX_READY,
    input wire logic RX_END,
    input wire logic [7:0] RSP_DATA,
    input wire logic RSP_VALID,
    input wire logic RSP_LAST,
    input wire logic RSP_READY,
    input wire logic REG_WE,
    input wire logic REG_RE,
    input wire logic CRC_FAULT,
    input wire logic FRAME_OK
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    // ==========================
    // frame verdict
    sequence s_end_taken;
        RX_VALID && RX_READY && RX_END;
    endsequence
    sequence s_verdict;
        CRC_FAULT || FRAME_OK;
    endsequence
    a_verdict_after_end: assert property (s_end_taken |-> ##[1:3] s_verdict)
        else $error("no verdict after frame end");
    a_fault_alone: assert property (CRC_FAULT |-> !FRAME_OK)
        else $error("fault and ok together");
    a_fault_no_write: assert property (CRC_FAULT |-> !REG_WE [*4])
        else $error("write after crc fault");
    a_fault_pulse: assert property (CRC_FAULT |=> !CRC_FAULT)
        else $error("fault longer than one cycle");
    a_ok_pulse: assert property (FRAME_OK |=> !FRAME_OK)
        else $error("ok longer than one cycle");
    // ==========================
    // response and register port
    a_rsp_hold: assert property (RSP_VALID && !RSP_READY |=>
        RSP_VALID && $stable(RSP_DATA) && $stable(RSP_LAST))
        else $error("response dropped while stalled");
    a_last_valid: assert property (RSP_LAST |-> RSP_VALID)
        else $error("last without valid");
    a_rsp_not_rx: assert property (RSP_VALID |-> !RX_READY)
        else $error("receiving while answering");
    a_we_re_excl: assert property (!(REG_WE && REG_RE))
        else $error("read and write strobes together");
endmodule // cfc_frame_assertions

bind cfc_frame cfc_frame_assertions cfc_frame_assertions_inst (
    .CLOCK(CLOCK), .RSTN(RSTN), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
    .RX_END(RX_END), .RSP_DATA(RSP_DATA), .RSP_VALID(RSP_VALID), .RSP_LAST(RSP_LAST),
    .RSP_READY(RSP_READY), .REG_WE(REG_WE), .REG_RE(REG_RE), .CRC_FAULT(CRC_FAULT),
    .FRAME_OK(FRAME_OK)
);

// ==== tb/cfc_regfile_model.sv ====
// register file stand-in on the handler's register port
`timescale 1ns/1ps
module cfc_regfile_model (
    input wire logic CLOCK,
    input wire logic REG_WE,
    input wire logic [15:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic REG_HIT
);
    logic [7:0] mem_reg [8];
    initial begin
        for (int i = 0; i < 8; i++) begin
            mem_reg[i] = 8'h10 + 8'(i);
        end
    end
    // only eight places exist; a miss shows junk so the handler must zero it
    assign REG_HIT = (REG_ADDR[15:3] == 13'h0060);
    assign REG_RDATA = REG_HIT ? mem_reg[REG_ADDR[2:0]] : 8'ha5;
    always @(posedge CLOCK) begin
        if (REG_WE && REG_HIT) begin
            mem_reg[REG_ADDR[2:0]] <= REG_WDATA;
        end
    end
endmodule // cfc_regfile_model

// ==== tb/chain_frame_crc_single_access_test.sv ====
// self-checking bench for the chain frame handler
`timescale 1ns/1ps
module chain_frame_crc_single_access_test;
    logic CLOCK = 1'b0;
    logic RSTN = 1'b0;
    logic [7:0] RX_DATA = 8'h00;
    logic RX_VALID = 1'b0;
    logic RX_END = 1'b0;
    logic stall = 1'b0;
    logic RX_READY, FWD_VALID, RSP_VALID, RSP_LAST, REG_WE, REG_RE, REG_HIT;
    logic CRC_FAULT, FRAME_OK, last_seen;
    logic [7:0] FWD_DATA, RSP_DATA, REG_WDATA, REG_RDATA;
    logic [15:0] REG_ADDR;
    logic [7:0] rsp_q[$];
    logic [7:0] fwd_q[$];
    int n_fail = 0, checks = 0, n_we = 0, n_ok = 0, n_bad = 0, n_fwd = 0, n_re = 0;
    int b_we, b_ok, b_bad, b_fwd, b_re;
    cfc_frame cfc_frame_inst (.CLOCK(CLOCK), .RSTN(RSTN), .DEV_ADDR(6'h02),
        .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_END(RX_END),
        .FWD_DATA(FWD_DATA), .FWD_VALID(FWD_VALID), .FWD_READY(!stall),
        .RSP_DATA(RSP_DATA), .RSP_VALID(RSP_VALID), .RSP_LAST(RSP_LAST),
        .RSP_READY(!stall), .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_HIT(REG_HIT),
        .CRC_FAULT(CRC_FAULT), .FRAME_OK(FRAME_OK));
    cfc_regfile_model cfc_regfile_model_inst (.CLOCK(CLOCK), .REG_WE(REG_WE),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .REG_HIT(REG_HIT));
    initial begin
        forever #10 CLOCK = ~CLOCK;
    end
    // both far sides stall every other cycle
    always @(negedge CLOCK) stall <= ~stall;
    always @(posedge CLOCK) begin
        if (REG_WE === 1'b1) n_we++;
        if (FRAME_OK === 1'b1) n_ok++;
        if (CRC_FAULT === 1'b1) n_bad++;
        if (REG_RE === 1'b1) n_re++;
        if (FWD_VALID === 1'b1 && !stall) begin
            n_fwd++;
            fwd_q.push_back(FWD_DATA);
        end
        if (RSP_VALID === 1'b1 && !stall) begin
            rsp_q.push_back(RSP_DATA);
            last_seen = RSP_LAST;
        end
    end
    // ==========================
    // shared tasks
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c = 16'hffff;
        foreach (b[i]) begin
            c ^= {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    task automatic complete_run();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic c, input string m);
        checks++;
        if (c !== 1'b1) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic hang(input string m);
        chk(1'b0, m);
        complete_run();
    endtask
    // sends a frame with its crc, flip corrupts the check field
    task automatic frame(input logic [7:0] f[$], input logic [15:0] flip);
        logic [15:0] c;
        int k;
        {b_we, b_ok, b_bad, b_fwd, b_re} = {n_we, n_ok, n_bad, n_fwd, n_re};
        fwd_q.delete();
        c = crc16(f) ^ flip;
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            RX_DATA = f[i];
            RX_VALID = 1'b1;
            RX_END = (i == f.size() - 1);
            for (k = 0; RX_READY !== 1'b1; k++) begin
                if (k > 200) hang("rx stalled");
                @(negedge CLOCK);
            end
            @(negedge CLOCK);
        end
        RX_VALID = 1'b0;
        RX_END = 1'b0;
        for (k = 0; n_ok + n_bad == b_ok + b_bad || RX_READY !== 1'b1
            || FWD_VALID === 1'b1; k++) begin
            if (k > 500) hang("frame not finished");
            @(negedge CLOCK);
        end
        foreach (f[i]) chk(fwd_q[i] === f[i], "relayed byte");
    endtask
    // ==========================
    // scenarios
    task automatic t_write();
        frame('{8'h93, 8'h02, 8'h03, 8'h00, 8'h02, 8'hb7, 8'h78, 8'hbc}, 16'h0000);
        chk(n_we - b_we === 4, "write count");
        chk(n_ok - b_ok === 1 && n_bad === b_bad, "good verdict");
        chk(n_fwd - b_fwd === 10, "relay count");
    endtask
    task automatic t_bad();
        frame('{8'h93, 8'h02, 8'h03, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00}, 16'h0001);
        chk(n_we === b_we, "bad frame wrote");
        chk(n_bad - b_bad === 1 && n_ok === b_ok, "bad verdict");
        chk(n_fwd - b_fwd === 10, "bad frame relay");
    endtask
    task automatic t_other();
        rsp_q.delete();
        frame('{8'h90, 8'h05, 8'h03, 8'h00, 8'h55}, 16'h0000);
        chk(n_we === b_we && n_ok - b_ok === 1, "foreign write");
        frame('{8'h80, 8'h05, 8'h03, 8'h00, 8'h00}, 16'h0000);
        chk(rsp_q.size() === 0, "foreign read answered");
        chk(n_re === b_re, "foreign read strobed");
    endtask
    task automatic t_read();
        logic [7:0] e[$];
        logic [15:0] c;
        rsp_q.delete();
        e = '{8'h78, 8'hbc, 8'h14, 8'h15, 8'h16, 8'h17, 8'h00, 8'h00};
        c = crc16(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        frame('{8'h80, 8'h02, 8'h03, 8'h02, 8'h07}, 16'h0000);
        chk(rsp_q.size() === e.size(), "response length");
        chk(n_re - b_re === 8, "read strobes");
        foreach (e[i]) chk(rsp_q[i] === e[i], "response byte");
        chk(last_seen === 1'b1, "last flag");
    endtask
    initial begin
        repeat (10) @(negedge CLOCK);
        RSTN = 1'b1;
        repeat (3) @(negedge CLOCK);
        t_write();
        t_bad();
        t_other();
        t_read();
        complete_run();
    end
endmodule // chain_frame_crc_single_access_test
